/* hvc_cal_seq.sv */
// VCO calibration sequencer: calibration clock divider, cycle counter, sync and done.
`timescale 1ns/1ps
module hvc_cal_seq
  import hvc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_pfd_event,
  input wire hvc_cal_cmd_t i_cmd,
  output hvc_cal_stat_t o_stat
);

  hvc_cal_state_t state_reg;
  hvc_cal_state_t state_next;
  logic [4:0] div_cnt_reg;
  logic [12:0] cyc_cnt_reg;
  logic done_reg;
  logic [4:0] div_ratio;
  logic cal_tick;
  logic cal_last;
  logic running;

  // Codes 0..3 divide the phase detector rate by 2, 4, 8 and 16.
  assign div_ratio = 5'h02 << i_cmd.div_sel;
  assign running = (state_reg == CAL_RUN);
  // The calibration clock is a one-cycle enable taken from phase detector events.
  assign cal_tick = running & i_pfd_event & (div_cnt_reg >= div_ratio - 5'h01);
  assign cal_last = cal_tick & (cyc_cnt_reg == CAL_LAST);

  // Only an explicit start leaves idle; without a reference the run simply stalls.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CAL_IDLE: if (i_cmd.start) state_next = CAL_RUN;
      CAL_RUN: if (cal_last) state_next = CAL_IDLE;
      default: state_next = CAL_IDLE;
    endcase
  end

  // State, divider and cycle counter.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= CAL_IDLE;
      div_cnt_reg <= 5'h00;
      cyc_cnt_reg <= 13'h0000;
    end
    else
    begin
      state_reg <= state_next;
      if (!running || cal_tick)
        div_cnt_reg <= 5'h00;
      else if (i_pfd_event)
        div_cnt_reg <= div_cnt_reg + 5'h01;
      if (!running)
        cyc_cnt_reg <= 13'h0000;
      else if (cal_tick)
        cyc_cnt_reg <= cyc_cnt_reg + 13'h0001;
    end
  end

  // Done clears at a new start and sets at the last calibration cycle.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      done_reg <= 1'b0;
    else if (cal_last)
      done_reg <= 1'b1;
    else if (state_reg == CAL_IDLE && i_cmd.start)
      done_reg <= 1'b0;
  end

  // Busy doubles as the output sync that holds the outputs static.
  assign o_stat = {running, done_reg};

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  cal_length_a: assert property ($rose(done_reg) |-> $past(cyc_cnt_reg) == CAL_LAST)
    else $error("Calibration ended at the wrong cycle count.");
  cal_start_a: assert property ($rose(running) |-> $past(i_cmd.start))
    else $error("Calibration began without a request.");
  sync_release_a: assert property ($fell(running) |-> done_reg)
    else $error("Output sync released without calibration done.");
  cal_div_a: assert property (cal_tick |-> div_cnt_reg + 5'h01 >= div_ratio)
    else $error("Calibration tick came before the divide ratio.");
  cal_done_c: cover property ($rose(done_reg));

endmodule

/* hvc_host_model.sv */
// Host controller model that drives the serial control port of the PLL control block.
`timescale 1ns/1ps
module hvc_host_model
  import hvc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic [DATA_W-1:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wdata
);
  // The port rests quiet from time zero.
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = '0;
    o_wdata = '0;
  end

  // One write strobe, raised just after an edge and taken at the next one.
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
  endtask

  // One read strobe; the data is registered, so it is taken just after the read edge.
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_sys_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    #1;
    d = i_rdata;
  endtask

  // Buffered writes only act once this command lands.
  task automatic update();
    wr_reg(OFS_UPDATE, 8'h01);
  endtask

  // Holdover goes off first, since it would reset the feedback divider mid-calibration.
  task automatic cal_request(input logic first, input logic [7:0] cfg);
    wr_reg(OFS_HOLDOVER, 8'h00);
    if (!first)
    begin
      wr_reg(OFS_LOCK_CAL, cfg);
      update();
    end
    wr_reg(OFS_LOCK_CAL, cfg | 8'h01);
    update();
  endtask
endmodule

/* hvc_pkg.sv */
// Shared constants, register map and types for the PLL holdover and calibration control.
package hvc_pkg;

  // Register port widths.
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;

  // Register offsets as seen on the serial control port.
  localparam logic [9:0] OFS_LOCK_CAL = 10'h018;
  localparam logic [9:0] OFS_LOCK_PIN = 10'h01a;
  localparam logic [9:0] OFS_REF_SEL = 10'h01c;
  localparam logic [9:0] OFS_HOLDOVER = 10'h01d;
  localparam logic [9:0] OFS_MON_THR = 10'h01f;
  localparam logic [9:0] OFS_UPDATE = 10'h232;

  // Storage index of each buffered register.
  localparam int unsigned NUM_REGS = 5;
  localparam int unsigned IDX_LOCK_CAL = 0;
  localparam int unsigned IDX_LOCK_PIN = 1;
  localparam int unsigned IDX_REF_SEL = 2;
  localparam int unsigned IDX_HOLDOVER = 3;
  localparam int unsigned IDX_MON_THR = 4;
  localparam logic [9:0] REG_OFS [NUM_REGS] = '{10'h018, 10'h01a, 10'h01c, 10'h01d, 10'h01f};

  // Writable bits per register; the calibration done bit is read only.
  localparam logic [7:0] REG_WMASK [NUM_REGS] = '{8'h7f, 8'h3f, 8'h1e, 8'h0b, 8'h03};
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions in the lock detect and calibration register.
  localparam int unsigned LC_CAL_BIT = 0;
  localparam int unsigned LC_CALDIV_LSB = 1;
  localparam int unsigned LC_DLD_DIS_BIT = 3;
  localparam int unsigned LC_CNT_LSB = 5;

  // Lock pin control field and its current source lock mode code.
  localparam int unsigned LP_CTRL_LSB = 0;
  localparam logic [5:0] LP_CS_MODE = 6'h04;

  // Reference select fields.
  localparam int unsigned RS_BUF_LSB = 1;
  localparam int unsigned RS_PREF_BIT = 3;
  localparam int unsigned RS_AUTO_BIT = 4;

  // Holdover control fields.
  localparam int unsigned HO_EN_BIT = 0;
  localparam int unsigned HO_EXT_BIT = 1;
  localparam int unsigned HO_COMP_BIT = 3;

  // Monitor threshold fields and calibration readback.
  localparam int unsigned MT_FIRST_REFERENCE_EXT_BIT = 0;
  localparam int unsigned MT_SECOND_REFERENCE_EXT_BIT = 1;
  localparam logic [7:0] MT_CAL_DONE_MASK = 8'h40;

  // Update command bit.
  localparam int unsigned UP_GO_BIT = 0;

  // Consecutive in-window phase detector cycles needed for lock, by code.
  localparam logic [7:0] LOCK_TARGET [4] = '{8'h05, 8'h10, 8'h40, 8'hff};

  // One calibration lasts this many calibration clock cycles.
  localparam int unsigned CAL_CYCLES = 4400;
  localparam int unsigned CAL_CNT_W = 13;
  localparam logic [12:0] CAL_LAST = 13'(CAL_CYCLES - 1);

  // Holdover state machine.
  typedef enum logic [2:0] {
    HO_WAIT = 3'b001,
    HO_ARMED = 3'b010,
    HO_ACTIVE = 3'b100
  } hvc_ho_state_t;

  // Calibration sequencer state machine.
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } hvc_cal_state_t;

  // Command from the register file to the calibration sequencer.
  typedef struct packed {
    logic start;
    logic [1:0] div_sel;
  } hvc_cal_cmd_t;

  // Status from the calibration sequencer.
  typedef struct packed {
    logic busy;
    logic done;
  } hvc_cal_stat_t;

endpackage

/* hvc_pll_ctrl.sv */
// PLL automatic holdover, lock detect counter, register file and calibration control.
//
// Behaviour
// - Holdover enabled: loss of lock tristates charge pump.
// - Entry decided by sensed lock indicator pin level.
// - Comparator disabled: pin sensed as always high.
// - Charge pump stays tristated while reference absent.
// - B counter reset on exit, at PHASE_DETECTOR event.
// - Pin must read high again before reentry.
// - Holdover follows only the selected reference.
// - Counter field sets cycles for lock; 00=5.
// - Digital lock detect runs only when enabled.
// - Holdover enable bit gates every holdover.
// - External control bit zero selects automatic holdover.
// - Pin control code 000100 selects current source mode.
// - Reference register: auto, preference, buffer enables.
// - Calibration starts only on explicit request.
// - Monitor thresholds normal or extended, by register.
// - Calibration clocked from divided reference; needs reference.
// - Readback bit shows calibration finished.
// - Output sync held during calibration only.
// - Calibration divider divides phase detector rate.
// - Calibration lasts 4400 calibration clock cycles.
`timescale 1ns/1ps
module hvc_pll_ctrl
  import hvc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  output logic [DATA_W-1:0] o_reg_rdata,
  input wire logic i_first_ref,
  input wire logic i_second_ref,
  input wire logic i_auto_sel_second,
  input wire logic [9:0] i_ref_div,
  input wire logic i_lock_indicator_pin,
  input wire logic i_pfd_in_window,
  output logic o_charge_pump_hiz,
  output logic o_b_counter_reset,
  output logic o_digital_lock_flag,
  output logic o_dld_enable,
  output logic [5:0] o_lock_pin_ctrl,
  output logic o_current_source_lock_mode,
  output logic [1:0] o_ref_buffer_en,
  output logic o_auto_switch_en,
  output logic o_prefer_second,
  output logic [1:0] o_mon_threshold_ext,
  output logic o_cal_sync,
  output logic o_cal_done
);

  logic [2:0] pin_in;
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [NUM_REGS-1:0] hit;
  logic [7:0] sh_reg [NUM_REGS];
  logic [7:0] act_reg [NUM_REGS];
  logic [7:0] rd_chain [NUM_REGS+1];
  logic [7:0] rd_mux;
  logic [7:0] rdata_reg;
  logic update_pulse;
  logic cal_bit_shadow;
  logic cal_bit_active;
  logic [1:0] cal_div_sel;
  logic dld_dis;
  logic [1:0] lock_sel;
  logic [7:0] lock_target;
  logic [5:0] lock_pin_ctrl;
  logic sel_second;
  logic [1:0] buf_en;
  logic sel_edge;
  logic ho_en;
  logic ho_ext;
  logic comp_en;
  logic ho_allowed;
  logic ld_seen;
  logic [9:0] rdiv_eff;
  logic [9:0] r_cnt_reg;
  logic pfd_event;
  logic [7:0] lock_cnt_reg;
  logic [8:0] lock_cnt_inc;
  logic dld_flag_reg;
  hvc_ho_state_t ho_state_reg;
  hvc_ho_state_t ho_next;
  logic cp_hiz_reg;
  logic breset_reg;
  logic breset_next;
  logic dld_en_reg;
  logic cs_mode_reg;
  hvc_cal_cmd_t cal_cmd;
  hvc_cal_stat_t cal_stat;

  // Pins from outside pass three flip-flops; a level only counts once stages two and three
  // agree, which rejects a single metastable sample.
  assign pin_in = {i_lock_indicator_pin, i_second_ref, i_first_ref};

  for (genvar g = 0; g < 3; g++)
  begin : g_pin_sync
    logic [2:0] sync_reg;
    logic level_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        sync_reg <= 3'h0;
        level_reg <= 1'b0;
      end
      else
      begin
        sync_reg <= {sync_reg[1:0], pin_in[g]};
        if (sync_reg[1] == sync_reg[2])
          level_reg <= sync_reg[2];
      end
    end
    assign pin_level[g] = level_reg;
    assign pin_rise[g] = (sync_reg[1] == sync_reg[2]) & sync_reg[2] & ~level_reg;
  end

  // Address decode; each register is written into a buffer and only takes effect on update.
  for (genvar i = 0; i < NUM_REGS; i++)
  begin : g_regs
    assign hit[i] = (i_reg_addr == REG_OFS[i]);
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        sh_reg[i] <= REG_RESET;
        act_reg[i] <= REG_RESET;
      end
      else
      begin
        if (i_reg_wr && hit[i])
          sh_reg[i] <= i_reg_wdata & REG_WMASK[i];
        if (update_pulse)
          act_reg[i] <= sh_reg[i];
      end
    end
    assign rd_chain[i+1] = rd_chain[i] | (hit[i] ? sh_reg[i] : 8'h00);
  end

  // Read mux; the update register and unmapped offsets read as zero.
  assign rd_chain[0] = 8'h00;
  assign rd_mux = rd_chain[NUM_REGS] | (hit[IDX_MON_THR] ? (MT_CAL_DONE_MASK & {8{cal_stat.done}})
    : 8'h00);
  assign update_pulse = i_reg_wr & (i_reg_addr == OFS_UPDATE) & i_reg_wdata[UP_GO_BIT];

  // Read data is registered and holds until the next read.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_reg <= 8'h00;
    else if (i_reg_rd)
      rdata_reg <= rd_mux;
  end

  // Fields of the active registers, plus the buffered calibrate bit.
  assign cal_bit_shadow = sh_reg[IDX_LOCK_CAL][LC_CAL_BIT];
  assign cal_bit_active = act_reg[IDX_LOCK_CAL][LC_CAL_BIT];
  assign cal_div_sel = act_reg[IDX_LOCK_CAL][LC_CALDIV_LSB +: 2];
  assign dld_dis = act_reg[IDX_LOCK_CAL][LC_DLD_DIS_BIT];
  assign lock_sel = act_reg[IDX_LOCK_CAL][LC_CNT_LSB +: 2];
  assign lock_pin_ctrl = act_reg[IDX_LOCK_PIN][LP_CTRL_LSB +: 6];
  assign buf_en = act_reg[IDX_REF_SEL][RS_BUF_LSB +: 2];
  assign ho_en = act_reg[IDX_HOLDOVER][HO_EN_BIT];
  assign ho_ext = act_reg[IDX_HOLDOVER][HO_EXT_BIT];
  assign comp_en = act_reg[IDX_HOLDOVER][HO_COMP_BIT];

  // Only the selected reference is watched; its input buffer must be enabled to see edges.
  assign sel_second = act_reg[IDX_REF_SEL][RS_AUTO_BIT] ? i_auto_sel_second
    : act_reg[IDX_REF_SEL][RS_PREF_BIT];
  assign sel_edge = sel_second ? (pin_rise[1] & buf_en[1]) : (pin_rise[0] & buf_en[0]);

  // Reference divider; a divide value of zero is treated as one.
  assign rdiv_eff = (i_ref_div == 10'h000) ? 10'h001 : i_ref_div;
  assign pfd_event = sel_edge & (r_cnt_reg >= rdiv_eff - 10'h001);

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      r_cnt_reg <= 10'h000;
    else if (pfd_event)
      r_cnt_reg <= 10'h000;
    else if (sel_edge)
      r_cnt_reg <= r_cnt_reg + 10'h001;
  end

  // Lock detect counter: consecutive in-window cycles raise the flag, one miss drops it.
  assign lock_target = LOCK_TARGET[lock_sel];
  assign lock_cnt_inc = {1'b0, lock_cnt_reg} + 9'h001;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lock_cnt_reg <= 8'h00;
      dld_flag_reg <= 1'b0;
    end
    else if (dld_dis)
    begin
      lock_cnt_reg <= 8'h00;
      dld_flag_reg <= 1'b0;
    end
    else if (pfd_event)
    begin
      lock_cnt_reg <= i_pfd_in_window ? ((lock_cnt_reg >= lock_target) ? lock_cnt_reg
        : lock_cnt_inc[7:0]) : 8'h00;
      dld_flag_reg <= i_pfd_in_window & (lock_cnt_inc >= {1'b0, lock_target});
    end
  end

  // Automatic holdover needs the enable, automatic source and a running lock detector.
  assign ho_allowed = ho_en & ~ho_ext & ~dld_dis;
  assign ld_seen = comp_en ? pin_level[2] : 1'b1;

  // Holdover sequence. Exit waits for a phase detector event on the selected reference, so a
  // lost reference keeps the pump tristated; a chattering lock flag can retrigger entry.
  always_comb
  begin
    ho_next = ho_state_reg;
    unique case (ho_state_reg)
      HO_WAIT: if (ho_allowed && ld_seen) ho_next = HO_ARMED;
      HO_ARMED:
      begin
        if (!ho_allowed)
          ho_next = HO_WAIT;
        else if (!ld_seen)
          ho_next = HO_ACTIVE;
      end
      HO_ACTIVE:
      begin
        if (!ho_en || pfd_event)
          ho_next = HO_WAIT;
      end
      default: ho_next = HO_WAIT;
    endcase
  end

  // The B counter reset coincides with the pump leaving high impedance on a reference event.
  assign breset_next = (ho_state_reg == HO_ACTIVE) & ho_en & pfd_event;

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ho_state_reg <= HO_WAIT;
      cp_hiz_reg <= 1'b0;
      breset_reg <= 1'b0;
    end
    else
    begin
      ho_state_reg <= ho_next;
      cp_hiz_reg <= (ho_next == HO_ACTIVE);
      breset_reg <= breset_next;
    end
  end

  // Configuration outputs that need decoding get their own flip-flops.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      dld_en_reg <= 1'b0;
      cs_mode_reg <= 1'b0;
    end
    else
    begin
      dld_en_reg <= ~dld_dis;
      cs_mode_reg <= (lock_pin_ctrl == LP_CS_MODE);
    end
  end

  // A calibration starts only when an update turns the calibrate bit from 0 to 1.
  // Holdover is not blocked during calibration; software must turn it off first.
  assign cal_cmd.start = update_pulse & cal_bit_shadow & ~cal_bit_active;
  assign cal_cmd.div_sel = cal_div_sel;

  hvc_cal_seq u_cal_seq (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pfd_event(pfd_event),
    .i_cmd(cal_cmd),
    .o_stat(cal_stat)
  );

  // Outputs, all taken from flip-flops except the sync, which is decoded from the sequencer state.
  assign o_reg_rdata = rdata_reg;
  assign o_charge_pump_hiz = cp_hiz_reg;
  assign o_b_counter_reset = breset_reg;
  assign o_digital_lock_flag = dld_flag_reg;
  assign o_dld_enable = dld_en_reg;
  assign o_lock_pin_ctrl = lock_pin_ctrl;
  assign o_current_source_lock_mode = cs_mode_reg;
  assign o_ref_buffer_en = buf_en;
  assign o_auto_switch_en = act_reg[IDX_REF_SEL][RS_AUTO_BIT];
  assign o_prefer_second = act_reg[IDX_REF_SEL][RS_PREF_BIT];
  assign o_mon_threshold_ext = {act_reg[IDX_MON_THR][MT_SECOND_REFERENCE_EXT_BIT],
    act_reg[IDX_MON_THR][MT_FIRST_REFERENCE_EXT_BIT]};
  assign o_cal_sync = cal_stat.busy;
  assign o_cal_done = cal_stat.done;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  hiz_entry_cause_a: assert property ($rose(cp_hiz_reg) |-> $past(ho_allowed && !ld_seen))
    else $error("Charge pump tristated without lock loss.");
  pin_level_a: assert property ($rose(cp_hiz_reg) |-> $past(comp_en && !pin_level[2]))
    else $error("Holdover entered while the sensed pin was high.");
  comp_off_a: assert property (!comp_en [*2] |-> !$rose(cp_hiz_reg))
    else $error("Holdover entered with the pin comparator disabled.");
  hiz_hold_a: assert property (cp_hiz_reg && ho_en && !pfd_event |=> cp_hiz_reg)
    else $error("Charge pump left holdover without a reference event.");
  breset_exit_a: assert property (breset_reg |-> $fell(cp_hiz_reg))
    else $error("B counter reset without leaving holdover.");
  rearm_a: assert property ($rose(cp_hiz_reg) |-> $past(ho_state_reg) == HO_ARMED)
    else $error("Holdover reentered without rearming.");
  lock_rise_a: assert property ($rose(dld_flag_reg) |-> $past(pfd_event && i_pfd_in_window
    && lock_cnt_inc >= {1'b0, lock_target}))
    else $error("Lock flag rose before enough in-window cycles.");
  dld_off_a: assert property (dld_dis |=> !dld_flag_reg && !dld_en_reg)
    else $error("Lock detector active while disabled.");
  ho_gate_a: assert property (!ho_en |=> !cp_hiz_reg)
    else $error("Charge pump tristated with holdover disabled.");
  ext_mode_a: assert property (ho_ext |=> !$rose(cp_hiz_reg))
    else $error("Automatic holdover entered in external mode.");
  cal_only_req_a: assert property ($rose(o_cal_sync) |-> $past(update_pulse))
    else $error("Calibration began without an update.");

  holdover_c: cover property ($rose(cp_hiz_reg));
  breset_c: cover property (breset_reg);
  lock_c: cover property ($rose(dld_flag_reg));
  cal_sync_c: cover property ($fell(o_cal_sync));

endmodule

/* tb_pll_holdover_and_vco_calibration.sv */
// Self-checking testbench for the PLL holdover and VCO calibration control.
`timescale 1ns/1ps
module tb_pll_holdover_and_vco_calibration
  import hvc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr;
  logic rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic first_ref = 1'b0;
  logic second_ref = 1'b0;
  logic auto_sel = 1'b0;
  logic [9:0] ref_div = 10'h001;
  logic lock_pin = 1'b0;
  logic in_window = 1'b0;
  logic ref_on = 1'b0;
  logic [1:0] ref_ph = 2'h0;
  logic hiz, brst, dlf, dlde, csm, ase, pref, csync, cdone;
  logic [5:0] lpc;
  logic [1:0] rbe;
  logic [1:0] mte;
  int ref_edges = 0;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] no_ho [3] = '{8'h01, 8'h08, 8'h0b};

  // The 200 MHz system clock.
  always #2.5 clk = ~clk;

  // Reference source, two cycles high and two low, so the pin synchroniser sees each level
  // twice; it rests low while off, so no phase detector event can occur then.
  always @(posedge clk)
  begin
    ref_ph <= ref_on ? ref_ph + 2'h1 : 2'h0;
    first_ref <= ref_on & ref_ph[1];
    if (ref_on && ref_ph[1] && !first_ref)
      ref_edges <= ref_edges + 1;
  end

  hvc_host_model host (.i_sys_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata));

  hvc_pll_ctrl dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_first_ref(first_ref),
    .i_second_ref(second_ref), .i_auto_sel_second(auto_sel), .i_ref_div(ref_div),
    .i_lock_indicator_pin(lock_pin), .i_pfd_in_window(in_window), .o_charge_pump_hiz(hiz),
    .o_b_counter_reset(brst), .o_digital_lock_flag(dlf), .o_dld_enable(dlde),
    .o_lock_pin_ctrl(lpc), .o_current_source_lock_mode(csm), .o_ref_buffer_en(rbe),
    .o_auto_switch_en(ase), .o_prefer_second(pref), .o_mon_threshold_ext(mte),
    .o_cal_sync(csync), .o_cal_done(cdone));

  // Every comparison funnels through here so the tally stays exact.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check1(input string what, input logic seen, input logic exp);
    check(what, {7'h00, seen}, {7'h00, exp});
  endtask

  // Lands just after an edge, so outputs are settled when looked at.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait on lock flag (0), charge pump tristate (1) or calibration done (2).
  task automatic wait_for(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? dlf : sel == 1 ? hiz : cdone) !== lvl && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A hang is cut off well after the first calibration and the cut-short second run should have finished.
  initial
  begin
    #450000;
    fails++;
    give_verdict();
  end

  // Main sequence: registers, lock detect, holdover, then two calibrations.
  initial
  begin
    logic [7:0] v;
    int e0;
    int n;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (REG_OFS[i])
    begin
      host.rd_reg(REG_OFS[i], v);
      check("reset value", v, REG_RESET);
      host.wr_reg(REG_OFS[i], 8'hff);
      host.rd_reg(REG_OFS[i], v);
      check("write mask", v, REG_WMASK[i]);
    end
    host.rd_reg(10'h100, v);
    check("unmapped read", v, 8'h00);
    check("buffered buffers", {6'h00, rbe}, 8'h00);
    check1("no self start", csync, 1'b0);
    host.wr_reg(OFS_LOCK_CAL, 8'h00);
    host.wr_reg(OFS_LOCK_PIN, 8'h04);
    host.wr_reg(OFS_REF_SEL, 8'h16);
    host.wr_reg(OFS_MON_THR, 8'h02);
    host.update();
    tick(3);
    check("pin control", {2'b00, lpc}, 8'h04);
    check1("current source mode", csm, 1'b1);
    check("reference controls", {3'h0, ase, pref, 1'b0, rbe}, 8'h13);
    check("monitor thresholds", {6'h00, mte}, 8'h02);
    check1("lock detect on", dlde, 1'b1);
    check1("update no start", csync, 1'b0);
    // Five in-window events give lock; the count covers synchroniser delay too.
    @(posedge clk);
    ref_on <= 1'b1;
    in_window <= 1'b1;
    e0 = ref_edges;
    wait_for(0, 1'b1, 100);
    check1("lock after five", 1'((ref_edges - e0) inside {[5:8]}), 1'b1);
    @(posedge clk);
    in_window <= 1'b0;
    wait_for(0, 1'b0, 10);
    check1("lock dropped", dlf, 1'b0);
    // Automatic holdover with the comparator, then exit on the next reference event.
    host.wr_reg(OFS_HOLDOVER, 8'h09);
    host.update();
    @(posedge clk);
    ref_on <= 1'b0;
    lock_pin <= 1'b1;
    tick(10);
    @(posedge clk);
    lock_pin <= 1'b0;
    wait_for(1, 1'b1, 10);
    check1("holdover entry", hiz, 1'b1);
    tick(50);
    check1("holdover held", hiz, 1'b1);
    @(posedge clk);
    ref_on <= 1'b1;
    wait_for(1, 1'b0, 20);
    check1("holdover exit", hiz, 1'b0);
    check1("b reset on exit", brst, 1'b1);
    tick(1);
    check1("b reset pulse", brst, 1'b0);
    tick(30);
    check1("no reentry low", hiz, 1'b0);
    // Comparator off, enable off or external control set must never tristate.
    foreach (no_ho[i])
    begin
      host.wr_reg(OFS_HOLDOVER, no_ho[i]);
      host.update();
      @(posedge clk);
      ref_on <= 1'b0;
      lock_pin <= 1'b1;
      tick(10);
      @(posedge clk);
      lock_pin <= 1'b0;
      tick(30);
      check1("no holdover", hiz, 1'b0);
    end
    // First calibration at divide code 0, then a recalibration at code 1.
    @(posedge clk);
    ref_on <= 1'b1;
    e0 = ref_edges;
    host.cal_request(1'b1, 8'h00);
    tick(2);
    check1("sync in calibration", csync, 1'b1);
    check1("done cleared", cdone, 1'b0);
    wait_for(2, 1'b1, 40000);
    check1("sync released", csync, 1'b0);
    check1("cal length", 1'((ref_edges - e0) inside {[8801:8810]}), 1'b1);
    host.rd_reg(OFS_MON_THR, v);
    check("done readback", v, 8'h42);
    e0 = ref_edges;
    host.cal_request(1'b0, 8'h02);
    tick(2);
    check1("recal sync", csync, 1'b1);
    // Past the ratio-two length a ratio of four is only half done; the run is cut there to
    // stay short, and a reset in mid-calibration must leave everything idle.
    n = 0;
    while (ref_edges - e0 < 8820 && n < 40000)
    begin
      tick(1);
      n++;
    end
    check1("recal still busy", csync, 1'b1);
    check("div four count", dut.u_cal_seq.cyc_cnt_reg[12:5], 8'h44);
    @(posedge clk);
    rst_n <= 1'b0;
    tick(6);
    @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    check1("reset ends sync", csync, 1'b0);
    check1("reset clears done", cdone, 1'b0);
    check1("reset no holdover", hiz, 1'b0);
    host.rd_reg(OFS_LOCK_CAL, v);
    check("reset control", v, REG_RESET);
    give_verdict();
  end
endmodule
